/* File: inc/adfr_pkg.sv */
// adfr_pkg: task-file map, opcodes, diagnostic codes and timing for the command block
package adfr_pkg;
  // task-file byte offsets
  localparam logic [9:0] ADFR_OFS_DATA = 10'h1F0;
  localparam logic [9:0] ADFR_OFS_ERROR_OR_FEATURES = 10'h1F1;
  localparam logic [9:0] ADFR_OFS_SECTOR_COUNT = 10'h1F2;
  localparam logic [9:0] ADFR_OFS_SECTOR_NUMBER = 10'h1F3;
  localparam logic [9:0] ADFR_OFS_CYLINDER_LOW = 10'h1F4;
  localparam logic [9:0] ADFR_OFS_CYLINDER_HIGH = 10'h1F5;
  localparam logic [9:0] ADFR_OFS_DRIVE_HEAD_SELECT = 10'h1F6;
  localparam logic [9:0] ADFR_OFS_COMMAND_OR_STATUS = 10'h1F7;
  // opcodes
  localparam logic [7:0] ADFR_OP_DIAG = 8'h90;
  localparam logic [7:0] ADFR_OP_FORMAT = 8'h50;
  localparam logic [7:0] ADFR_OP_RDLONG = 8'h22;
  localparam logic [7:0] ADFR_OP_RDLONG_MASK = 8'hFE;
  // diagnostic codes
  localparam logic [7:0] ADFR_DIAG_PASS = 8'h01;
  localparam logic [7:0] ADFR_DIAG_BUF_ERR = 8'h03;
  localparam logic [7:0] ADFR_DIAG_ROM_ERR = 8'h05;
  localparam logic [7:0] ADFR_DIAG_DEV1_FAIL = 8'h80;
  // completion values
  localparam logic [7:0] ADFR_DIAG_ZERO = 8'h00;
  localparam logic [7:0] ADFR_DIAG_ONE = 8'h01;
  localparam logic [7:0] ADFR_RL_OK_COUNT = 8'h00;
  localparam logic [7:0] ADFR_RL_ERR_COUNT = 8'h01;
  localparam logic [7:0] ADFR_ERR_ABORT = 8'h04;
  localparam logic [7:0] ADFR_ERR_UNC = 8'h40;
  // status bits
  localparam int ADFR_ST_BSY = 7;
  localparam int ADFR_ST_DRDY = 6;
  localparam int ADFR_ST_DSC = 4;
  localparam int ADFR_ST_DRQ = 3;
  localparam int ADFR_ST_ERR = 0;
  // drive/head fields
  localparam int ADFR_DH_DEV = 4;
  localparam int ADFR_DH_LBA = 6;
  // sizes
  localparam int ADFR_SECTOR_WORDS = 256;
  localparam int ADFR_ECC_BYTES = 4;
  localparam int ADFR_ECC_WORDS = ADFR_ECC_BYTES / 2;
  // timing
  localparam longint ADFR_CLK_HZ = 100000000;
  localparam longint ADFR_PDIAG_WAIT_S = 5;
  localparam longint ADFR_PDIAG_WAIT_CYC = ADFR_PDIAG_WAIT_S * ADFR_CLK_HZ;
endpackage

/* File: core/adfr_fifo.sv */
// adfr_fifo: synchronous valid/ready FIFO for the data port
`timescale 1ns/1ps
module adfr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem[rd_ptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else if (flush_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

/* File: core/adfr_cmd.sv */
// adfr_cmd: diagnostic, format-track and long-read handling behind the task file
`timescale 1ns/1ps
// Contract
// - opcode 90h starts internal self test
// - diagnostic ignores the device select bit
// - each device runs its own self test
// - device 0 waits up to 5 s
// - device 1 failure ORs 80h into code
// - both devices clear busy, only device 0 interrupts
// - alone, device 0 reports own result only
// - codes 01 pass, 03, 05, 8x
// - completion loads 00, 00, 00, 01, 01
// - opcode 50h takes 512 bytes under DRQ
// - format leaves medium alone, then interrupts
// - long read accepts 22h or 23h
// - long read sends data then ECC bytes
// - no ECC correction on long read
// - long read moves exactly one sector
// - sector count 00 ok, 01 on error
// - address kept, error register informs
module adfr_cmd
  import adfr_pkg::*;
#(
  parameter longint PDIAG_WAIT_CYC = ADFR_PDIAG_WAIT_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // strap: this drive is device 1
  input wire logic is_dev1_i,
  // task-file access
  input wire logic [9:0] tf_addr_i,
  input wire logic tf_wr_i,
  input wire logic tf_rd_i,
  input wire logic [15:0] tf_wdata_i,
  output logic [15:0] tf_rdata_o,
  output logic intrq_o,
  // diagnostic pins
  input wire logic dasp_n_i,
  input wire logic pdiag_n_i,
  output logic pdiag_n_o,
  output logic pdiag_n_oe_o,
  // self test engine
  output logic selftest_start_o,
  input wire logic selftest_done_i,
  input wire logic [7:0] selftest_code_i,
  // media read port: raw words, sector then ECC
  output logic media_rd_req_o,
  output logic [27:0] media_addr_o,
  output logic media_lba_o,
  input wire logic media_valid_i,
  output logic media_ready_o,
  input wire logic [15:0] media_data_i,
  input wire logic media_err_i
);
  typedef enum logic [2:0] {
    ADFR_IDLE, ADFR_DIAG_RUN, ADFR_DIAG_WAIT, ADFR_FMT_XFER, ADFR_RL_XFER
  } adfr_state_e;

  adfr_state_e state_ff;
  logic [7:0] err_ff, sc_ff, sn_ff, cl_ff, ch_ff, dh_ff, feat_ff;
  logic bsy_ff, drq_ff, errb_ff, intrq_ff, drdy_ff;
  logic [7:0] own_code_ff;
  localparam int WAIT_W = $clog2(PDIAG_WAIT_CYC + 1);
  logic [WAIT_W-1:0] wait_ff;
  logic [8:0] wcnt_ff;
  logic [15:0] rdata_ff;
  logic rl_err_ff;
  logic [1:0] pdiag_sync_ff, dasp_sync_ff;
  logic dev1_seen_ff;
  logic fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush;
  logic [15:0] fifo_out_data;
  logic cmd_wr, data_rd, data_wr, sel_me, sel_ok;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    return a == ofs;
  endfunction

  // pin synchronisers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pdiag_sync_ff <= 2'h3;
      dasp_sync_ff <= 2'h3;
    end else begin
      pdiag_sync_ff <= {pdiag_sync_ff[0], pdiag_n_i};
      dasp_sync_ff <= {dasp_sync_ff[0], dasp_n_i};
    end
  end

  // device 1 presence seen on its activity line after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dev1_seen_ff <= 1'b0;
    end else if (!dasp_sync_ff[1]) begin
      dev1_seen_ff <= 1'b1;
    end
  end

  assign sel_me = (dh_ff[ADFR_DH_DEV] == is_dev1_i);
  assign sel_ok = sel_me || (dh_ff[ADFR_DH_DEV] && !is_dev1_i && !dev1_seen_ff);
  assign cmd_wr = tf_wr_i && hit(tf_addr_i, ADFR_OFS_COMMAND_OR_STATUS) && !bsy_ff;
  assign data_wr = tf_wr_i && hit(tf_addr_i, ADFR_OFS_DATA) && drq_ff
                   && state_ff == ADFR_FMT_XFER && sel_me;
  assign data_rd = tf_rd_i && hit(tf_addr_i, ADFR_OFS_DATA) && drq_ff
                   && state_ff == ADFR_RL_XFER && sel_me && fifo_out_valid;
  assign fifo_pop = data_rd;
  assign fifo_flush = (state_ff != ADFR_RL_XFER);

  adfr_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(fifo_flush),
    .in_valid_i(media_valid_i),
    .in_ready_o(fifo_in_ready),
    .in_data_i(media_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );
  // raw media words go straight to the host, never corrected
  assign media_ready_o = fifo_in_ready && state_ff == ADFR_RL_XFER;
  assign media_addr_o = {dh_ff[3:0], ch_ff, cl_ff, sn_ff};
  assign media_lba_o = dh_ff[ADFR_DH_LBA];

  // command sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ADFR_IDLE;
      wait_ff <= '0;
      wcnt_ff <= '0;
      own_code_ff <= ADFR_DIAG_PASS;
      rl_err_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ADFR_IDLE: begin
          wcnt_ff <= '0;
          rl_err_ff <= 1'b0;
          if (cmd_wr && tf_wdata_i[7:0] == ADFR_OP_DIAG) begin
            state_ff <= ADFR_DIAG_RUN;
          end else if (cmd_wr && sel_me && tf_wdata_i[7:0] == ADFR_OP_FORMAT) begin
            state_ff <= ADFR_FMT_XFER;
          end else if (cmd_wr && sel_me
                       && (tf_wdata_i[7:0] & ADFR_OP_RDLONG_MASK) == ADFR_OP_RDLONG) begin
            state_ff <= ADFR_RL_XFER;
          end
        end
        ADFR_DIAG_RUN: begin
          wait_ff <= '0;
          if (selftest_done_i) begin
            own_code_ff <= selftest_code_i;
            state_ff <= (is_dev1_i || !dev1_seen_ff) ? ADFR_IDLE : ADFR_DIAG_WAIT;
          end
        end
        ADFR_DIAG_WAIT: begin
          wait_ff <= wait_ff + 1'b1;
          if (!pdiag_sync_ff[1] || wait_ff == WAIT_W'(PDIAG_WAIT_CYC - 1)) begin
            state_ff <= ADFR_IDLE;
          end
        end
        ADFR_FMT_XFER: begin
          if (data_wr) begin
            wcnt_ff <= wcnt_ff + 1'b1;
            if (wcnt_ff == 9'(ADFR_SECTOR_WORDS - 1)) begin
              state_ff <= ADFR_IDLE;
            end
          end
        end
        ADFR_RL_XFER: begin
          if (media_err_i) begin
            rl_err_ff <= 1'b1;
          end
          if (data_rd) begin
            wcnt_ff <= wcnt_ff + 1'b1;
            if (wcnt_ff == 9'(ADFR_SECTOR_WORDS + ADFR_ECC_WORDS - 1)) begin
              state_ff <= ADFR_IDLE;
            end
          end
        end
        default: state_ff <= ADFR_IDLE;
      endcase
    end
  end

  assign selftest_start_o = (state_ff == ADFR_IDLE) && cmd_wr && tf_wdata_i[7:0] == ADFR_OP_DIAG;
  assign media_rd_req_o = (state_ff == ADFR_IDLE) && cmd_wr && sel_me
                          && (tf_wdata_i[7:0] & ADFR_OP_RDLONG_MASK) == ADFR_OP_RDLONG;

  // device 1 asserts its pass line once its own test passes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pdiag_n_oe_o <= 1'b1;
    end else if (state_ff == ADFR_IDLE && cmd_wr && tf_wdata_i[7:0] == ADFR_OP_DIAG) begin
      pdiag_n_oe_o <= 1'b1;
    end else if (is_dev1_i && state_ff == ADFR_DIAG_RUN && selftest_done_i
                 && selftest_code_i == ADFR_DIAG_PASS) begin
      pdiag_n_oe_o <= 1'b0;
    end
  end
  assign pdiag_n_o = 1'b0;

  // task-file registers and status
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_ff <= ADFR_DIAG_PASS;
      feat_ff <= '0;
      sc_ff <= ADFR_DIAG_ONE;
      sn_ff <= ADFR_DIAG_ONE;
      cl_ff <= '0;
      ch_ff <= '0;
      dh_ff <= '0;
      bsy_ff <= 1'b0;
      drq_ff <= 1'b0;
      errb_ff <= 1'b0;
      intrq_ff <= 1'b0;
      drdy_ff <= 1'b1;
    end else begin
      if (tf_rd_i && hit(tf_addr_i, ADFR_OFS_COMMAND_OR_STATUS) && sel_me) begin
        intrq_ff <= 1'b0;
      end
      if (tf_wr_i && !bsy_ff && !drq_ff) begin
        if (hit(tf_addr_i, ADFR_OFS_ERROR_OR_FEATURES)) feat_ff <= tf_wdata_i[7:0];
        if (hit(tf_addr_i, ADFR_OFS_SECTOR_COUNT)) sc_ff <= tf_wdata_i[7:0];
        if (hit(tf_addr_i, ADFR_OFS_SECTOR_NUMBER)) sn_ff <= tf_wdata_i[7:0];
        if (hit(tf_addr_i, ADFR_OFS_CYLINDER_LOW)) cl_ff <= tf_wdata_i[7:0];
        if (hit(tf_addr_i, ADFR_OFS_CYLINDER_HIGH)) ch_ff <= tf_wdata_i[7:0];
      end
      if (tf_wr_i && hit(tf_addr_i, ADFR_OFS_DRIVE_HEAD_SELECT) && !bsy_ff) begin
        dh_ff <= tf_wdata_i[7:0];
      end
      unique case (state_ff)
        ADFR_IDLE: begin
          if (cmd_wr && tf_wdata_i[7:0] == ADFR_OP_DIAG) begin
            bsy_ff <= 1'b1;
            errb_ff <= 1'b0;
            intrq_ff <= 1'b0;
          end else if (cmd_wr && sel_me && tf_wdata_i[7:0] == ADFR_OP_FORMAT) begin
            drq_ff <= 1'b1;
            errb_ff <= 1'b0;
            intrq_ff <= 1'b0;
          end else if (cmd_wr && sel_me
                       && (tf_wdata_i[7:0] & ADFR_OP_RDLONG_MASK) == ADFR_OP_RDLONG) begin
            drq_ff <= 1'b1;
            errb_ff <= 1'b0;
            intrq_ff <= 1'b0;
          end else if (cmd_wr && sel_me) begin
            err_ff <= ADFR_ERR_ABORT;
            errb_ff <= 1'b1;
            intrq_ff <= 1'b1;
          end
        end
        ADFR_DIAG_RUN: begin
          if (selftest_done_i && (is_dev1_i || !dev1_seen_ff)) begin
            err_ff <= selftest_code_i;
            dh_ff <= ADFR_DIAG_ZERO;
            ch_ff <= ADFR_DIAG_ZERO;
            cl_ff <= ADFR_DIAG_ZERO;
            sn_ff <= ADFR_DIAG_ONE;
            sc_ff <= ADFR_DIAG_ONE;
            bsy_ff <= 1'b0;
            intrq_ff <= !is_dev1_i;
          end
        end
        ADFR_DIAG_WAIT: begin
          if (!pdiag_sync_ff[1] || wait_ff == WAIT_W'(PDIAG_WAIT_CYC - 1)) begin
            err_ff <= pdiag_sync_ff[1] ? (own_code_ff | ADFR_DIAG_DEV1_FAIL)
                                       : own_code_ff;
            dh_ff <= ADFR_DIAG_ZERO;
            ch_ff <= ADFR_DIAG_ZERO;
            cl_ff <= ADFR_DIAG_ZERO;
            sn_ff <= ADFR_DIAG_ONE;
            sc_ff <= ADFR_DIAG_ONE;
            bsy_ff <= 1'b0;
            intrq_ff <= 1'b1;
          end
        end
        ADFR_FMT_XFER: begin
          if (data_wr && wcnt_ff == 9'(ADFR_SECTOR_WORDS - 1)) begin
            drq_ff <= 1'b0;
            intrq_ff <= 1'b1;
          end
        end
        ADFR_RL_XFER: begin
          if (data_rd && wcnt_ff == 9'(ADFR_SECTOR_WORDS + ADFR_ECC_WORDS - 1)) begin
            drq_ff <= 1'b0;
            intrq_ff <= 1'b1;
            sc_ff <= (rl_err_ff || media_err_i) ? ADFR_RL_ERR_COUNT : ADFR_RL_OK_COUNT;
            errb_ff <= rl_err_ff || media_err_i;
            err_ff <= (rl_err_ff || media_err_i) ? ADFR_ERR_UNC : 8'h00;
          end
        end
        default: bsy_ff <= 1'b0;
      endcase
    end
  end

  // read mux, registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else if (tf_rd_i) begin
      rdata_ff <= '0;
      if (hit(tf_addr_i, ADFR_OFS_DATA) && data_rd) rdata_ff <= fifo_out_data;
      if (sel_ok) begin
        if (hit(tf_addr_i, ADFR_OFS_ERROR_OR_FEATURES)) rdata_ff[7:0] <= err_ff;
        if (hit(tf_addr_i, ADFR_OFS_SECTOR_COUNT)) rdata_ff[7:0] <= sc_ff;
        if (hit(tf_addr_i, ADFR_OFS_SECTOR_NUMBER)) rdata_ff[7:0] <= sn_ff;
        if (hit(tf_addr_i, ADFR_OFS_CYLINDER_LOW)) rdata_ff[7:0] <= cl_ff;
        if (hit(tf_addr_i, ADFR_OFS_CYLINDER_HIGH)) rdata_ff[7:0] <= ch_ff;
        if (hit(tf_addr_i, ADFR_OFS_DRIVE_HEAD_SELECT)) rdata_ff[7:0] <= dh_ff;
        if (hit(tf_addr_i, ADFR_OFS_COMMAND_OR_STATUS)) begin
          rdata_ff[ADFR_ST_BSY] <= bsy_ff;
          rdata_ff[ADFR_ST_DRDY] <= drdy_ff;
          rdata_ff[ADFR_ST_DSC] <= 1'b1;
          // long read shows data request only while a word waits
          rdata_ff[ADFR_ST_DRQ] <= drq_ff && (state_ff != ADFR_RL_XFER || fifo_out_valid);
          rdata_ff[ADFR_ST_ERR] <= errb_ff;
        end
      end
    end
  end
  assign tf_rdata_o = rdata_ff;
  assign intrq_o = intrq_ff && sel_me;
endmodule

/* File: verif/adfr_cmd_props.sv */
// adfr_cmd_props: port-level checks of the command block
`timescale 1ns/1ps
module adfr_cmd_props
  import adfr_pkg::*;
#(
  parameter longint PDIAG_WAIT_CYC = ADFR_PDIAG_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic is_dev1_i,
  input wire logic [9:0] tf_addr_i,
  input wire logic tf_wr_i,
  input wire logic [15:0] tf_wdata_i,
  input wire logic intrq_o,
  input wire logic dasp_n_i,
  input wire logic pdiag_n_o,
  input wire logic pdiag_n_oe_o,
  input wire logic selftest_start_o,
  input wire logic selftest_done_i,
  input wire logic [7:0] selftest_code_i,
  input wire logic media_rd_req_o,
  input wire logic [27:0] media_addr_o,
  input wire logic media_lba_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] sn_ff, cl_ff, ch_ff, dh_ff;
  logic dev1_ff;
  logic pend_ff;
  longint wait_ff;
  logic cmd_wr;
  assign cmd_wr = tf_wr_i && tf_addr_i == ADFR_OFS_COMMAND_OR_STATUS;
  // shadow of the address registers
  always_ff @(posedge clk_i) begin
    if (tf_wr_i && tf_addr_i == ADFR_OFS_SECTOR_NUMBER) sn_ff <= tf_wdata_i[7:0];
    if (tf_wr_i && tf_addr_i == ADFR_OFS_CYLINDER_LOW) cl_ff <= tf_wdata_i[7:0];
    if (tf_wr_i && tf_addr_i == ADFR_OFS_CYLINDER_HIGH) ch_ff <= tf_wdata_i[7:0];
    if (tf_wr_i && tf_addr_i == ADFR_OFS_DRIVE_HEAD_SELECT) dh_ff <= tf_wdata_i[7:0];
  end
  // cycles from self-test done to the interrupt
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dev1_ff <= 1'b0;
      pend_ff <= 1'b0;
      wait_ff <= 0;
    end else begin
      dev1_ff <= dev1_ff | !dasp_n_i;
      pend_ff <= (pend_ff | selftest_done_i) & !intrq_o & !is_dev1_i;
      wait_ff <= pend_ff ? wait_ff + 1 : 0;
    end
  end
  a_diag_cause: assert property (
    selftest_start_o |-> cmd_wr && tf_wdata_i[7:0] == ADFR_OP_DIAG)
    else $error("self test started without command");
  a_start_single: assert property (
    selftest_start_o |=> !selftest_start_o)
    else $error("self test start longer than one cycle");
  a_rdlong_cause: assert property (
    media_rd_req_o |-> cmd_wr && (tf_wdata_i[7:0] & ADFR_OP_RDLONG_MASK) == ADFR_OP_RDLONG)
    else $error("media read without long read command");
  a_one_sector: assert property (
    media_rd_req_o |=> !media_rd_req_o [*8])
    else $error("second media request for one command");
  a_media_addr: assert property (
    media_rd_req_o |-> media_addr_o == {dh_ff[3:0], ch_ff, cl_ff, sn_ff} && media_lba_o == dh_ff[6])
    else $error("media address differs from task file");
  a_pdiag_low: assert property (
    !pdiag_n_oe_o |-> !pdiag_n_o)
    else $error("diagnostic line driven high");
  a_dev0_silent: assert property (
    !is_dev1_i |-> pdiag_n_oe_o)
    else $error("device 0 drives diagnostic line");
  a_dev1_pass: assert property (
    is_dev1_i && selftest_done_i && selftest_code_i == ADFR_DIAG_PASS |=> !pdiag_n_oe_o)
    else $error("device 1 did not signal its pass");
  a_solo_done: assert property (
    selftest_done_i && !dev1_ff |-> ##[1:3] intrq_o)
    else $error("no interrupt after solo diagnostic");
  a_wait_bound: assert property (
    wait_ff <= PDIAG_WAIT_CYC + 8)
    else $error("diagnostic wait too long");
  c_solo: cover property (selftest_done_i && !dev1_ff);
  c_pair: cover property (selftest_done_i && dev1_ff);
  c_rdlong: cover property (media_rd_req_o);
endmodule

bind adfr_cmd adfr_cmd_props #(.PDIAG_WAIT_CYC(PDIAG_WAIT_CYC)) adfr_cmd_props_i (
  .clk_i, .rst_n_i, .is_dev1_i, .tf_addr_i, .tf_wr_i, .tf_wdata_i, .intrq_o, .dasp_n_i,
  .pdiag_n_o, .pdiag_n_oe_o, .selftest_start_o, .selftest_done_i, .selftest_code_i,
  .media_rd_req_o, .media_addr_o, .media_lba_o
);

/* File: verif/adfr_dev_model.sv */
// adfr_dev_model: self-test engine and media stream behind the command block
`timescale 1ns/1ps
module adfr_dev_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // self test side
  input wire logic st_start_i,
  input wire logic [7:0] st_code_i,
  output logic st_done_o,
  output logic [7:0] st_code_o,
  // media side
  input wire logic rd_req_i,
  input wire logic [27:0] addr_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [15:0] data_o
);
  int st_cnt;
  int idx;
  logic [15:0] base;
  assign st_code_o = st_done_o ? st_code_i : ~st_code_i;
  assign data_o = valid_o ? base + 16'(idx) : ~(base + 16'(idx));
  // self test lasts 20 cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_cnt <= 0;
      st_done_o <= 1'b0;
    end else begin
      st_done_o <= (st_cnt == 1);
      if (st_start_i) st_cnt <= 20;
      else if (st_cnt > 0) st_cnt <= st_cnt - 1;
    end
  end
  // 258 raw words with random stalls, held until taken
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx <= 258;
      base <= 16'h0000;
      valid_o <= 1'b0;
    end else if (rd_req_i) begin
      idx <= 0;
      base <= addr_i[15:0];
      valid_o <= 1'b0;
    end else if (valid_o) begin
      if (ready_i) begin
        idx <= idx + 1;
        valid_o <= (idx < 257) && ($urandom % 4 != 0);
      end
    end else begin
      valid_o <= (idx < 258) && ($urandom % 4 != 0);
    end
  end
endmodule

/* File: verif/adfr_cmd_tb_top.sv */
// adfr_cmd_tb_top: self-checking bench for the command block
`timescale 1ns/1ps
module adfr_cmd_tb_top import adfr_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [9:0] ta = ADFR_OFS_DATA;
  logic tw = 1'b0;
  logic tr = 1'b0;
  logic [15:0] twd = 16'h0000;
  logic [7:0] st_code = 8'h01;
  logic dasp_n = 1'b1;
  logic pdiag_n = 1'b1;
  logic merr = 1'b0;
  logic dev1_strap = 1'b0;
  logic [15:0] rdat, mdata, d;
  logic intrq, pdo, pdoe, st_start, st_done, rd_req, mlba, mvalid, mready;
  logic [7:0] st_code_d;
  logic [27:0] maddr;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [15:0] q[$];
  logic [7:0] codes[3] = '{8'h01, 8'h03, 8'h05};

  always #5 clk_i = ~clk_i;

  adfr_cmd #(.PDIAG_WAIT_CYC(50), .FIFO_DEPTH(8)) adfr_cmd_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .is_dev1_i(dev1_strap), .tf_addr_i(ta), .tf_wr_i(tw),
    .tf_rd_i(tr), .tf_wdata_i(twd), .tf_rdata_o(rdat), .intrq_o(intrq), .dasp_n_i(dasp_n),
    .pdiag_n_i(pdiag_n & (pdoe | pdo)), .pdiag_n_o(pdo), .pdiag_n_oe_o(pdoe),
    .selftest_start_o(st_start), .selftest_done_i(st_done), .selftest_code_i(st_code_d),
    .media_rd_req_o(rd_req), .media_addr_o(maddr), .media_lba_o(mlba),
    .media_valid_i(mvalid), .media_ready_o(mready), .media_data_i(mdata), .media_err_i(merr));

  adfr_dev_model adfr_dev_model_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .st_start_i(st_start), .st_code_i(st_code),
    .st_done_o(st_done), .st_code_o(st_code_d), .rd_req_i(rd_req), .addr_i(maddr),
    .ready_i(mready), .valid_o(mvalid), .data_o(mdata));

  task automatic results();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    ta = a;
    twd = v;
    tw = 1'b1;
    @(negedge clk_i);
    tw = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [9:0] a, output logic [15:0] v);
    ta = a;
    tr = 1'b1;
    @(negedge clk_i);
    tr = 1'b0;
    v = rdat;
    @(negedge clk_i);
  endtask

  task automatic wait_irq(input int n);
    for (int i = 0; i < n && intrq !== 1'b1; i++) @(negedge clk_i);
    chk({15'h0000, intrq}, 16'h0001);
  endtask

  task automatic poll(input logic [15:0] m, input logic [15:0] v);
    for (int i = 0; i < 3000; i++) begin
      rd(ADFR_OFS_COMMAND_OR_STATUS, d);
      if ((d & m) === v) break;
    end
    chk(d & m, v);
  endtask

  task automatic diag(input logic [7:0] code, input bit dev1, input bit pass1);
    logic [7:0] ex[6];
    ex = '{(dev1 && !pass1) ? (code | 8'h80) : code, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    st_code = code;
    wr(ADFR_OFS_DRIVE_HEAD_SELECT, dev1 ? 16'h00A0 : 16'h00B0);
    wr(ADFR_OFS_COMMAND_OR_STATUS, {8'h00, ADFR_OP_DIAG});
    @(negedge clk_i);
    rd(ADFR_OFS_COMMAND_OR_STATUS, d);
    chk(d & 16'h0080, 16'h0080);
    if (dev1 && pass1) begin
      repeat (30) @(negedge clk_i);
      pdiag_n = 1'b0;
    end
    wait_irq(300);
    for (int k = 0; k < 6; k++) begin
      rd(10'(ADFR_OFS_ERROR_OR_FEATURES + k), d);
      chk(d & 16'h00FF, {8'h00, ex[k]});
    end
    poll(16'h0088, 16'h0000);
    pdiag_n = 1'b1;
  endtask

  task automatic rdlong(input logic [7:0] op, input bit err);
    logic [7:0] r[4];
    int n;
    n = 0;
    foreach (r[k]) r[k] = 8'($urandom);
    r[3] = (r[3] & 8'h4F) | 8'hA0;
    for (int k = 0; k < 4; k++) wr(10'(ADFR_OFS_SECTOR_NUMBER + k), {8'h00, r[k]});
    for (int i = 0; i < 258; i++) q.push_back({r[1], r[0]} + 16'(i));
    merr = err;
    wr(ADFR_OFS_COMMAND_OR_STATUS, {8'h00, op});
    for (int i = 0; i < 4000; i++) begin
      rd(ADFR_OFS_COMMAND_OR_STATUS, d);
      if (d[3] === 1'b1) begin
        rd(ADFR_OFS_DATA, d);
        n++;
        if (!err && q.size() > 0) chk(d, q.pop_front());
      end else if (d[7] === 1'b0 && (n == 258 || d[0] === 1'b1)) break;
    end
    q.delete();
    merr = 1'b0;
    if (!err) chk(16'(n), 16'h0102);
    rd(ADFR_OFS_ERROR_OR_FEATURES, d);
    chk(d & 16'h00FF, err ? 16'h0040 : 16'h0000);
    rd(ADFR_OFS_SECTOR_COUNT, d);
    chk(d & 16'h00FF, err ? 16'h0001 : 16'h0000);
    for (int k = 0; k < 4; k++) begin
      rd(10'(ADFR_OFS_SECTOR_NUMBER + k), d);
      chk(d & 16'h00FF, {8'h00, r[k]});
    end
  endtask

  initial begin
    void'($urandom(70179));
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    foreach (codes[k]) diag(codes[k], 1'b0, 1'b0);
    wr(ADFR_OFS_COMMAND_OR_STATUS, {8'h00, ADFR_OP_FORMAT});
    poll(16'h0088, 16'h0008);
    for (int i = 0; i < 256; i++) wr(ADFR_OFS_DATA, 16'($urandom));
    wait_irq(20);
    poll(16'h0088, 16'h0000);
    rdlong(8'h22, 1'b0);
    rdlong(8'h23, 1'b0);
    rdlong(8'h22, 1'b1);
    wr(ADFR_OFS_COMMAND_OR_STATUS, 16'h0024);
    rd(ADFR_OFS_ERROR_OR_FEATURES, d);
    chk(d & 16'h00FF, {8'h00, ADFR_ERR_ABORT});
    dasp_n = 1'b0;
    diag(8'h01, 1'b1, 1'b1);
    diag(8'h05, 1'b1, 1'b0);
    // second reset: same block strapped as device 1
    rst_n_i = 1'b0;
    dev1_strap = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    st_code = ADFR_DIAG_PASS;
    wr(ADFR_OFS_DRIVE_HEAD_SELECT, 16'h00B0);
    wr(ADFR_OFS_COMMAND_OR_STATUS, {8'h00, ADFR_OP_DIAG});
    repeat (40) @(negedge clk_i);
    chk({15'h0000, pdoe}, 16'h0000);
    wr(ADFR_OFS_DRIVE_HEAD_SELECT, 16'h00B0);
    chk({15'h0000, intrq}, 16'h0000);
    rd(ADFR_OFS_ERROR_OR_FEATURES, d);
    chk(d & 16'h00FF, 16'h0001);
    rd(ADFR_OFS_COMMAND_OR_STATUS, d);
    chk(d & 16'h0080, 16'h0000);
    results();
  end
endmodule
